// ---- pkg/tsq_map.svh ----
// Purpose: register offsets, field positions, reset values and counts of the trigger sequencer
// Assumes: APB with 32-bit data, one aligned word for each register
// Notes: header of definitions only
`ifndef TSQ_MAP_SVH
`define TSQ_MAP_SVH

// register byte offsets
`define TSQ_A_CST 8'h00
`define TSQ_A_CFG 8'h04
`define TSQ_A_BTE 8'h08
`define TSQ_A_T0 8'h0C
`define TSQ_A_T1 8'h10
`define TSQ_A_SD 8'h14
`define TSQ_A_C0 8'h18
`define TSQ_A_C1 8'h1C
`define TSQ_A_STAT 8'h20
`define TSQ_A_QUE 8'h40

// sequencer_control_status fields
`define TSQ_B_EN 15
`define TSQ_B_SIDL 13
`define TSQ_B_TOGL 12
`define TSQ_B_SWT 10
`define TSQ_B_SSEN 9
`define TSQ_B_IVIS 8
`define TSQ_B_STRT 7
`define TSQ_B_WDTO 6
`define TSQ_B_ITM_LVL 1
`define TSQ_B_ITM_NODLY 0
`define TSQ_CST_WMASK 16'hB383
`define TSQ_RST_CST 16'h0000

// configuration fields
`define TSQ_CFG_DIV_HI 12
`define TSQ_CFG_DIV_LO 8
`define TSQ_CFG_PWD_HI 7
`define TSQ_CFG_PWD_LO 4
`define TSQ_CFG_WDT_HI 2
`define TSQ_CFG_WDT_LO 0
`define TSQ_CFG_WMASK 16'h1FF7
`define TSQ_RST_CFG 16'h0000
`define TSQ_RST_LIM 16'h0000
`define TSQ_WDT_BASE 16'h0008

// counter slots, in register order from TSQ_A_T0
`define TSQ_CT_T0 0
`define TSQ_CT_T1 1
`define TSQ_CT_SD 2
`define TSQ_CT_C0 3
`define TSQ_CT_C1 4
`define TSQ_NCNT 5

// control step command options
`define TSQ_OPT_SWT 4'h1
`define TSQ_OPT_T0 4'h2
`define TSQ_OPT_T1 4'h3
`define TSQ_OPT_BCAST 4'hF

`endif

// ---- pkg/tsq_pkg.sv ----
// Purpose: types of the trigger sequencer
// Assumes: constants live in tsq_map.svh
// Notes: step command = opcode in bits 7:4, argument in bits 3:0
package tsq_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH = 3'b001,
    S_WAIT = 3'b010,
    S_DELAY = 3'b011,
    S_PAUSE = 3'b100
  } state_e;

  typedef enum logic [3:0] {
    OP_CTRL = 4'h0,
    OP_WHI = 4'h1,
    OP_WLO = 4'h2,
    OP_TRIG = 4'h3,
    OP_IRQ = 4'h4,
    OP_LOOP0 = 4'h5,
    OP_LOOP1 = 4'h6,
    OP_JUMP = 4'h7
  } op_e;
endpackage : tsq_pkg

// ---- logic/tsq_cnt.sv ----
// Purpose: 16-bit counter compared against a limit
// Assumes: clear has priority over increment
// Notes: used for both timers, the step delay and both limit counters
`timescale 1ns/1ns
`default_nettype none
module tsq_cnt #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // control
  input wire logic clr_i,
  input wire logic inc_i,
  input wire logic [W-1:0] lim_i,
  // state
  output logic [W-1:0] val_o,
  output logic hit_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I || clr_i) begin
      cnt_q <= '0;
    end else if (inc_i) begin
      cnt_q <= W'(cnt_q + 1'b1);
    end
  end

  assign val_o = cnt_q;
  assign hit_o = (cnt_q == lim_i);
endmodule : tsq_cnt
`default_nettype wire

// ---- logic/tsq_top.sv ----
// Purpose: trigger sequencer running a queue of 8-bit step commands
// Assumes: APB slave with zero wait states; IDLE_I comes from logic on MCLK_I
// Notes: trigger inputs are resynchronised, so edges closer than 1 clock can merge
`timescale 1ns/1ns
`default_nettype none
`include "tsq_map.svh"
// Behaviour
// (RL1) steps are 8-bit commands fetched in order from the software-loaded queue
// (RL2) steps wait on inputs, emit output triggers, or wait on timers
// (RL3) two independent 16-bit timers serve timer-wait steps
// (RL4) two independent 16-bit limit counters count loop iterations against a limit
// (RL5) input waits react to a rising or a falling edge
// (RL6) four interrupt outputs asserted by steps where software places them
// (RL7) an interrupt follows each completed step in single-step mode
// (RL8) an interrupt is raised when the sequencer watchdog times out
// (RL9) trigger inputs from converter, modulators, compare, capture, comparators, pin two
// (RL10) trigger outputs to watchdog, compare, capture, converter, modulators, comparators
// (RL11) idle-stop bit 13 set halts the sequencer in idle; clear keeps it running
// (RL12) toggle bit 12 set makes each trigger step invert the selected line
// (RL13) toggle bit clear makes each trigger step emit one pulse of programmed width
// (RL14) watchdog timeout flag is set only by hardware and resets to zero
// (RL15) broadcast map and limits are read-only while enabled and started
// (RL16) software trigger bit releases a software-trigger control step or a single-step pause; zero does nothing
// (RL17) two-bit input mode picks edge or level detect and delay on exit
// (RL18) step delay equals the delay limit plus one, counted in module clock ticks
// (RL19) start bit set while enabled runs the queue; clearing it stops
// (RL20) single-step runs one step, then pauses until a software trigger
// (RL21) visibility bit makes limit registers read back live counts
module tsq_top #(
  parameter int QDEPTH = 16,
  parameter int NTRIG = 16
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // device power state
  input wire logic IDLE_I,
  // peripheral triggers
  input wire logic [NTRIG-1:0] TRIG_IN_I,
  output logic [NTRIG-1:0] TRIG_OUT_O,
  output logic [15:0] BCAST_O,
  // interrupts
  output logic [3:0] IRQ_O,
  output logic SSTEP_IRQ_O,
  output logic WDTO_IRQ_O
);
  localparam int QW = $clog2(QDEPTH);

  logic [15:0] cst_q;
  logic [15:0] cfg_q;
  logic [15:0] bte_q;
  logic [15:0] lim_q [`TSQ_NCNT];
  logic [7:0] que_q [QDEPTH];
  logic wdto_q;
  logic [31:0] rd_q;
  tsq_pkg::state_e state_q;
  logic [QW-1:0] ptr_q;
  logic [QW-1:0] nptr_q;
  logic [7:0] cmd_q;
  logic [4:0] div_q;
  logic [15:0] wd_q;
  logic [3:0] pwc_q;
  logic [NTRIG-1:0] s1_q, s2_q, prev_q, out_q;
  logic [3:0] irq_q;
  logic [15:0] bc_q;
  logic sstep_q, wdirq_q;

  logic wr, rd_setup, wr_cst, locked, run, tick, swt_wr;
  logic [NTRIG-1:0] rise, fall, trig_oh;
  logic [7:0] cur;
  tsq_pkg::op_e cur_op, wop;
  logic [3:0] cur_arg, warg;
  logic fire_trig, fire_irq, fire_bc, needs_wait, jump, wait_met, nodly, step_done, wd_exp;
  logic [`TSQ_NCNT-1:0] cnt_clr, cnt_inc, cnt_hit;
  logic [15:0] cnt_val [`TSQ_NCNT];
  logic [15:0] wd_lim;
  logic [2:0] wd_sel;

  // apb decode; writes land in the access phase, read data is latched in setup
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign wr_cst = wr && (PADDR_I == `TSQ_A_CST);
  assign swt_wr = wr_cst && PWDATA_I[`TSQ_B_SWT];
  assign locked = cst_q[`TSQ_B_EN] && cst_q[`TSQ_B_STRT];
  assign run = locked && !(IDLE_I && cst_q[`TSQ_B_SIDL]); // see (RL11)
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !((PADDR_I[1:0] == 2'b00)
    && (PADDR_I <= `TSQ_A_STAT || PADDR_I[7:6] == 2'b01));
  assign PRDATA_O = rd_q;

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cst_q <= `TSQ_RST_CST;
    end else begin
      if (wr_cst) begin
        cst_q <= PWDATA_I[15:0] & `TSQ_CST_WMASK; // see (RL19)
      end
      if (wd_exp) begin
        cst_q[`TSQ_B_STRT] <= 1'b0;
      end
    end
  end

  // hardware set wins over a software write of zero
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      wdto_q <= 1'b0; // see (RL14)
    end else if (wd_exp) begin
      wdto_q <= 1'b1; // see (RL14)
    end else if (wr_cst && !PWDATA_I[`TSQ_B_WDTO]) begin
      wdto_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      cfg_q <= `TSQ_RST_CFG;
      bte_q <= `TSQ_RST_LIM;
      for (int i = 0; i < `TSQ_NCNT; i++) begin
        lim_q[i] <= `TSQ_RST_LIM;
      end
    end else if (wr) begin
      if (PADDR_I == `TSQ_A_CFG) begin
        cfg_q <= PWDATA_I[15:0] & `TSQ_CFG_WMASK;
      end
      if (PADDR_I == `TSQ_A_BTE && !locked) begin
        bte_q <= PWDATA_I[15:0]; // see (RL15)
      end
      for (int i = 0; i < `TSQ_NCNT; i++) begin
        if (PADDR_I == 8'(`TSQ_A_T0 + 4 * i) && !locked) begin
          lim_q[i] <= PWDATA_I[15:0]; // see (RL15)
        end
      end
    end
  end

  // queue stays writable at all times so software can patch ahead of the pointer
  always_ff @(posedge MCLK_I) begin
    if (wr && PADDR_I[7:6] == 2'b01) begin
      que_q[PADDR_I[QW+1:2]] <= PWDATA_I[7:0]; // see (RL1)
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rd_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      rd_q <= 32'h0000_0000;
      unique case (PADDR_I)
        `TSQ_A_CST: rd_q[15:0] <= cst_q | {9'h000, wdto_q, 6'h00};
        `TSQ_A_CFG: rd_q[15:0] <= cfg_q;
        `TSQ_A_BTE: rd_q[15:0] <= bte_q;
        `TSQ_A_STAT: rd_q[15:0] <= {5'h00, state_q, 4'h0, 4'(ptr_q)};
        default: begin
          for (int i = 0; i < `TSQ_NCNT; i++) begin
            if (PADDR_I == 8'(`TSQ_A_T0 + 4 * i)) begin
              rd_q[15:0] <= cst_q[`TSQ_B_IVIS] ? cnt_val[i] : lim_q[i]; // see (RL21)
            end
          end
          if (PADDR_I[7:6] == 2'b01) begin
            rd_q[7:0] <= que_q[PADDR_I[QW+1:2]];
          end
        end
      endcase
    end
  end

  // module clock: divide by field + 1
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || !cst_q[`TSQ_B_EN] || tick) begin
      div_q <= 5'h00;
    end else begin
      div_q <= 5'(div_q + 1'b1);
    end
  end
  assign tick = cst_q[`TSQ_B_EN] && (div_q == cfg_q[`TSQ_CFG_DIV_HI:`TSQ_CFG_DIV_LO]);

  // bit map of inputs: 0-3 converter, 4-7 modulators, 8-9 compare, 10-11 capture, 12-14 comparators, 15 pin two
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      s1_q <= '0;
      s2_q <= '0;
      prev_q <= '0;
    end else begin
      s1_q <= TRIG_IN_I; // see (RL9)
      s2_q <= s1_q;
      prev_q <= s2_q;
    end
  end
  assign rise = s2_q & ~prev_q; // see (RL5)
  assign fall = ~s2_q & prev_q; // see (RL5)

  assign cur = (state_q == tsq_pkg::S_FETCH) ? que_q[ptr_q] : cmd_q;
  assign cur_op = tsq_pkg::op_e'(cur[7:4]);
  assign cur_arg = cur[3:0];
  assign wop = tsq_pkg::op_e'(cmd_q[7:4]);
  assign warg = cmd_q[3:0];
  assign trig_oh = {{(NTRIG-1){1'b0}}, 1'b1} << cur_arg;
  assign nodly = (wop == tsq_pkg::OP_WHI || wop == tsq_pkg::OP_WLO) && cst_q[`TSQ_B_ITM_NODLY]; // see (RL17)

  always_comb begin
    fire_trig = 1'b0;
    fire_irq = 1'b0;
    fire_bc = 1'b0;
    needs_wait = 1'b0;
    jump = 1'b0;
    wait_met = 1'b0;
    cnt_clr = '0;
    cnt_inc = '0;
    if (state_q == tsq_pkg::S_FETCH && run) begin
      cnt_clr[`TSQ_CT_SD] = 1'b1;
      unique case (cur_op)
        tsq_pkg::OP_CTRL: begin
          needs_wait = (cur_arg == `TSQ_OPT_SWT) || (cur_arg == `TSQ_OPT_T0) || (cur_arg == `TSQ_OPT_T1);
          cnt_clr[`TSQ_CT_T0] = (cur_arg == `TSQ_OPT_T0); // see (RL3)
          cnt_clr[`TSQ_CT_T1] = (cur_arg == `TSQ_OPT_T1);
          fire_bc = (cur_arg == `TSQ_OPT_BCAST);
        end
        tsq_pkg::OP_WHI, tsq_pkg::OP_WLO: needs_wait = 1'b1; // see (RL2)
        tsq_pkg::OP_TRIG: fire_trig = 1'b1; // see (RL2)
        tsq_pkg::OP_IRQ: fire_irq = 1'b1; // see (RL6)
        tsq_pkg::OP_LOOP0, tsq_pkg::OP_LOOP1: begin
          // command bit 5 tells the two loop steps apart: clear for counter 0, set for counter 1
          if (cnt_hit[`TSQ_CT_C0 + int'(cur[5])]) begin
            cnt_clr[`TSQ_CT_C0 + int'(cur[5])] = 1'b1; // see (RL4)
          end else begin
            cnt_inc[`TSQ_CT_C0 + int'(cur[5])] = 1'b1; // see (RL4)
            jump = 1'b1;
          end
        end
        tsq_pkg::OP_JUMP: jump = 1'b1;
        default: ;
      endcase
    end
    if (state_q == tsq_pkg::S_WAIT && run) begin
      unique case (wop)
        tsq_pkg::OP_WHI: wait_met = cst_q[`TSQ_B_ITM_LVL] ? s2_q[warg] : rise[warg]; // see (RL17)
        tsq_pkg::OP_WLO: wait_met = cst_q[`TSQ_B_ITM_LVL] ? !s2_q[warg] : fall[warg];
        default: begin
          if (warg == `TSQ_OPT_SWT) begin
            wait_met = swt_wr; // see (RL16)
          end else begin
            wait_met = tick && cnt_hit[`TSQ_CT_T0 + int'(warg[0])]; // see (RL3)
            cnt_inc[`TSQ_CT_T0 + int'(warg[0])] = tick && !cnt_hit[`TSQ_CT_T0 + int'(warg[0])];
          end
        end
      endcase
    end
    if (state_q == tsq_pkg::S_DELAY && run) begin
      cnt_inc[`TSQ_CT_SD] = tick && !cnt_hit[`TSQ_CT_SD]; // see (RL18)
    end
  end

  assign step_done = (state_q == tsq_pkg::S_DELAY && run && tick && cnt_hit[`TSQ_CT_SD])
    || (wait_met && nodly);

  for (genvar g = 0; g < `TSQ_NCNT; g++) begin : g_cnt
    tsq_cnt #(.W(16)) u_cnt (
      .MCLK_I(MCLK_I),
      .SRST_I(SRST_I),
      .clr_i(cnt_clr[g]),
      .inc_i(cnt_inc[g]),
      .lim_i(lim_q[g]),
      .val_o(cnt_val[g]),
      .hit_o(cnt_hit[g])
    );
  end

  // watchdog only runs while a step waits; code 0 disables it
  assign wd_sel = cfg_q[`TSQ_CFG_WDT_HI:`TSQ_CFG_WDT_LO];
  assign wd_lim = `TSQ_WDT_BASE << (wd_sel - 3'd1);
  assign wd_exp = state_q == tsq_pkg::S_WAIT && run && tick && wd_sel != 3'd0 && wd_q == wd_lim && !wait_met;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I || state_q != tsq_pkg::S_WAIT) begin
      wd_q <= 16'h0000;
    end else if (run && tick) begin
      wd_q <= 16'(wd_q + 1'b1);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      state_q <= tsq_pkg::S_IDLE;
      ptr_q <= '0;
      nptr_q <= '0;
      cmd_q <= 8'h00;
    end else if (!cst_q[`TSQ_B_EN]) begin
      state_q <= tsq_pkg::S_IDLE;
      ptr_q <= '0;
    end else if (!cst_q[`TSQ_B_STRT] || wd_exp) begin
      state_q <= tsq_pkg::S_IDLE; // see (RL19)
    end else if (run) begin
      unique case (state_q)
        tsq_pkg::S_IDLE: state_q <= tsq_pkg::S_FETCH;
        tsq_pkg::S_FETCH: begin
          cmd_q <= cur; // see (RL1)
          nptr_q <= jump ? QW'(cur_arg) : QW'(ptr_q + 1'b1);
          state_q <= needs_wait ? tsq_pkg::S_WAIT : tsq_pkg::S_DELAY;
        end
        tsq_pkg::S_WAIT, tsq_pkg::S_DELAY: begin
          if (step_done) begin
            ptr_q <= nptr_q;
            state_q <= cst_q[`TSQ_B_SSEN] ? tsq_pkg::S_PAUSE : tsq_pkg::S_FETCH; // see (RL20)
          end else if (wait_met) begin
            state_q <= tsq_pkg::S_DELAY;
          end
        end
        tsq_pkg::S_PAUSE: begin
          if (swt_wr) begin
            state_q <= tsq_pkg::S_FETCH; // see (RL20)
          end
        end
      endcase
    end
  end

  // output pulse spans pwd + 1 ticks; the first tick may be partial
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      out_q <= '0;
      pwc_q <= 4'h0;
    end else if (fire_trig) begin
      out_q <= cst_q[`TSQ_B_TOGL] ? (out_q ^ trig_oh) : (out_q | trig_oh); // see (RL12)
      pwc_q <= 4'h0;
    end else if (!cst_q[`TSQ_B_TOGL] && |out_q && tick) begin
      if (pwc_q == cfg_q[`TSQ_CFG_PWD_HI:`TSQ_CFG_PWD_LO]) begin
        out_q <= '0; // see (RL13)
      end else begin
        pwc_q <= 4'(pwc_q + 1'b1);
      end
    end
  end
  assign TRIG_OUT_O = out_q; // see (RL10)

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      irq_q <= 4'h0;
      bc_q <= 16'h0000;
      sstep_q <= 1'b0;
      wdirq_q <= 1'b0;
    end else begin
      irq_q <= fire_irq ? (4'h1 << cur_arg[1:0]) : 4'h0; // see (RL6)
      bc_q <= fire_bc ? bte_q : 16'h0000; // see (RL10)
      sstep_q <= step_done && cst_q[`TSQ_B_SSEN]; // see (RL7)
      wdirq_q <= wd_exp; // see (RL8)
    end
  end
  assign IRQ_O = irq_q;
  assign BCAST_O = bc_q;
  assign SSTEP_IRQ_O = sstep_q;
  assign WDTO_IRQ_O = wdirq_q;

  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  trig_toggle_a: assert property (fire_trig && cst_q[`TSQ_B_TOGL] |=> out_q == $past(out_q ^ trig_oh)) // see (RL12)
    else $error("toggle step did not invert its line");
  trig_pulse_a: assert property (fire_trig && !cst_q[`TSQ_B_TOGL] |=> (out_q & $past(trig_oh)) != '0) // see (RL13)
    else $error("pulse step did not raise its line");
  irq_step_a: assert property (fire_irq |=> IRQ_O == (4'h1 << $past(cur_arg[1:0])) ##1 IRQ_O == 4'h0) // see (RL6)
    else $error("step interrupt wrong or not one cycle");
  sstep_pause_a: assert property (step_done && cst_q[`TSQ_B_SSEN] && !wd_exp && cst_q[`TSQ_B_STRT] // see (RL7)
    |=> SSTEP_IRQ_O && state_q == tsq_pkg::S_PAUSE)
    else $error("single step did not pause with interrupt");
  wdto_flag_a: assert property (wd_exp |=> wdto_q && WDTO_IRQ_O && !cst_q[`TSQ_B_STRT]) // see (RL8)
    else $error("watchdog expiry not flagged");
  idle_hold_a: assert property (locked && IDLE_I && cst_q[`TSQ_B_SIDL] && !wr_cst // see (RL11)
    |=> $stable(ptr_q) && $stable(state_q))
    else $error("sequencer moved while idle-stopped");
  limit_lock_a: assert property (locked && wr && PADDR_I == `TSQ_A_T0 |=> $stable(lim_q[`TSQ_CT_T0])) // see (RL15)
    else $error("limit written while locked");
  swt_release_a: assert property (state_q == tsq_pkg::S_WAIT && run && !wd_exp // see (RL16)
    && wop == tsq_pkg::OP_CTRL && warg == `TSQ_OPT_SWT && swt_wr |=> state_q != tsq_pkg::S_WAIT)
    else $error("software trigger did not release wait");
  edge_rise_a: assert property (state_q == tsq_pkg::S_WAIT && run && wop == tsq_pkg::OP_WHI // see (RL5)
    && !cst_q[`TSQ_B_ITM_LVL] && rise[warg] && cst_q[`TSQ_B_STRT] |=> state_q != tsq_pkg::S_WAIT)
    else $error("rising edge did not end wait");
  delay_end_a: assert property (state_q == tsq_pkg::S_DELAY && run && tick && cnt_hit[`TSQ_CT_SD] // see (RL18)
    && cst_q[`TSQ_B_STRT] |=> state_q != tsq_pkg::S_DELAY)
    else $error("step delay overran its limit");
endmodule : tsq_top
`default_nettype wire

// ---- bench/tsq_periph.sv ----
// Purpose: model of the peripherals that trade trigger lines with the sequencer
// Assumes: each peripheral follows its requested level lag_i + 1 clocks later
// Notes: records rising edges, last pulse width and last broadcast map
`timescale 1ns/1ns
`default_nettype none
module tsq_periph (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SRST_I,
  // requested levels and answer lag
  input wire logic [15:0] want_i,
  input wire logic [3:0] lag_i,
  // trigger lines
  output logic [15:0] trig_o = 16'h0000,
  input wire logic [15:0] tout_i,
  input wire logic [15:0] bcast_i
);
  int lag_q = 0;
  int rise_q [16] = '{default: 0};
  int wid_q [16] = '{default: 0};
  int run_q [16] = '{default: 0};
  logic [15:0] bc_q = 16'h0000;

  // a slow peripheral holds its old level until the lag runs out
  always @(posedge MCLK_I) begin
    if (SRST_I || want_i == trig_o) begin
      lag_q <= 0;
    end else if (lag_q >= int'(lag_i)) begin
      trig_o <= want_i;
    end else begin
      lag_q <= lag_q + 1;
    end
  end

  always @(posedge MCLK_I) begin
    for (int i = 0; i < 16; i++) begin
      if (tout_i[i] === 1'b1) begin
        run_q[i] <= run_q[i] + 1;
        if (run_q[i] == 0) begin
          rise_q[i] <= rise_q[i] + 1;
        end
      end else if (run_q[i] > 0) begin
        wid_q[i] <= run_q[i];
        run_q[i] <= 0;
      end
    end
    if (bcast_i !== 16'h0000) begin
      bc_q <= bcast_i;
    end
  end
endmodule : tsq_periph
`default_nettype wire

// ---- bench/tb_tsq_top.sv ----
// Purpose: self-checking bench of the trigger sequencer
// Assumes: zero wait state APB slave, one tick per clock with divider 0
// Notes: every run is stopped and reloaded, so tests count pulses as deltas
`timescale 1ns/1ns
`default_nettype none
`include "tsq_map.svh"
module tb_tsq_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic idle = 1'b0;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [15:0] want = 16'h0000;
  logic [3:0] lag = 4'h1;
  logic [31:0] prd;
  logic [31:0] rd;
  logic [15:0] trin;
  logic [15:0] tout;
  logic [15:0] bc;
  logic [3:0] irq;
  logic prdy;
  logic perr;
  logic er;
  logic ss;
  logic wd;
  logic [7:0] prog [16] = '{default: 8'h01};
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int irq_n [4] = '{default: 0};
  int irq_t [4] = '{default: 0};
  int ss_n = 0;
  int wd_n = 0;
  int b;
  int t;
  int d;

  always #20 clk = ~clk;

  tsq_top dut_u (.MCLK_I(clk), .SRST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
    .IDLE_I(idle), .TRIG_IN_I(trin), .TRIG_OUT_O(tout), .BCAST_O(bc), .IRQ_O(irq),
    .SSTEP_IRQ_O(ss), .WDTO_IRQ_O(wd));

  tsq_periph p_u (.MCLK_I(clk), .SRST_I(rst), .want_i(want), .lag_i(lag), .trig_o(trin),
    .tout_i(tout), .bcast_i(bc));

  task stop_test;
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // pulse counters, and the run ceiling (about twelve times the expected length)
  always @(posedge clk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 4; i++) begin
      if (irq[i] === 1'b1) begin
        irq_n[i] <= irq_n[i] + 1;
        irq_t[i] <= cyc;
      end
    end
    if (ss === 1'b1) ss_n <= ss_n + 1;
    if (wd === 1'b1) wd_n <= wd_n + 1;
    if (cyc >= 30000) begin
      fail_count++;
      stop_test();
    end
  end

  // wide enough that packed pairs of counts are compared whole
  task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task xfer(input logic [7:0] a, input logic w, input logic [31:0] dat);
    @(posedge clk);
    psel <= 1'b1;
    padr <= a;
    pwr <= w;
    pwd <= dat;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer

  // queue is loaded while stopped; the fill step waits for a software trigger
  task start(input logic [15:0] cst);
    for (int i = 0; i < 16; i++) xfer(`TSQ_A_QUE + 8'(4 * i), 1'b1, {24'h0, prog[i]});
    for (int i = 0; i < 16; i++) prog[i] = 8'h01;
    xfer(`TSQ_A_CST, 1'b1, {16'h0, cst});
    t = cyc;
  endtask : start

  task halt;
    xfer(`TSQ_A_CST, 1'b1, 32'h0);
  endtask : halt

  task wait_irq(input int i, input int base);
    for (int n = 0; n < 200 && irq_n[i] <= base; n++) @(posedge clk);
  endtask : wait_irq

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 9; a++) begin
      xfer(8'(4 * a), 1'b0, 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    xfer(8'h3C, 1'b0, 32'h0);
    chk({er, rd}, {1'b1, 32'h0}, "unmapped access");
    xfer(`TSQ_A_CST, 1'b1, 32'h0040);
    xfer(`TSQ_A_CST, 1'b0, 32'h0);
    chk(rd, 32'h0, "flag set by software");
    xfer(`TSQ_A_CFG, 1'b1, 32'h0030);
    prog[0] = 8'h33;
    start(16'h8080);
    repeat (20) @(posedge clk);
    chk(p_u.wid_q[3], 4, "pulse width");
    halt();
    prog[0] = 8'h33;
    prog[1] = 8'h33;
    b = p_u.rise_q[3];
    start(16'h9080);
    repeat (20) @(posedge clk);
    chk({tout[3], p_u.wid_q[3]}, {1'b0, 32'd2}, "toggled line");
    chk(p_u.rise_q[3] - b, 1, "toggle rises");
    for (int k = 0; k < 2; k++) begin
      halt();
      xfer(`TSQ_A_T0 + 8'(4 * k), 1'b1, 32'(20 + 10 * k));
      prog[0] = 8'(2 + k);
      prog[1] = 8'h43;
      b = irq_n[3];
      start(16'h8080);
      wait_irq(3, b);
      d = irq_t[3] - t;
      chk(d >= 21 + 10 * k && d <= 29 + 10 * k, 1, "timer wait");
    end
    halt();
    xfer(`TSQ_A_T0, 1'b1, 32'h3E8);
    prog[0] = 8'h02;
    start(16'h8080);
    xfer(`TSQ_A_T0, 1'b1, 32'h55);
    xfer(`TSQ_A_BTE, 1'b1, 32'h5);
    xfer(`TSQ_A_T0, 1'b0, 32'h0);
    chk(rd, 32'h3E8, "locked limit");
    xfer(`TSQ_A_BTE, 1'b0, 32'h0);
    chk(rd, 32'h0, "locked map");
    xfer(`TSQ_A_CST, 1'b1, 32'h8180);
    xfer(`TSQ_A_T0, 1'b0, 32'h0);
    d = int'(rd);
    repeat (5) @(posedge clk);
    xfer(`TSQ_A_T0, 1'b0, 32'h0);
    chk(int'(rd) > d && int'(rd) < d + 16, 1, "live timer");
    halt();
    xfer(`TSQ_A_BTE, 1'b1, 32'h00A5);
    prog[0] = 8'h0F;
    start(16'h8080);
    repeat (20) @(posedge clk);
    chk(p_u.bc_q, 16'h00A5, "broadcast map");
    for (int k = 0; k < 2; k++) begin
      halt();
      xfer(`TSQ_A_C0 + 8'(4 * k), 1'b1, 32'h2);
      prog[0] = 8'h40;
      prog[1] = 8'(8'h50 + 16 * k);
      b = irq_n[0];
      start(16'h8080);
      repeat (40) @(posedge clk);
      chk(irq_n[0] - b, 3, "loop passes");
    end
    halt();
    prog[0] = 8'h40;
    prog[1] = 8'h70;
    b = irq_n[0];
    start(16'h8080);
    repeat (30) @(posedge clk);
    xfer(`TSQ_A_CST, 1'b1, 32'h8000);
    // a step fetched in the stop cycle still shows up two edges later
    repeat (2) @(posedge clk);
    d = irq_n[0];
    repeat (20) @(posedge clk);
    chk({d > b, irq_n[0] - d}, {1'b1, 32'd0}, "start and stop");
    halt();
    xfer(`TSQ_A_CFG, 1'b1, 32'h0001);
    b = wd_n;
    start(16'h8080);
    repeat (40) @(posedge clk);
    xfer(`TSQ_A_CST, 1'b0, 32'h0);
    chk({wd_n - b, rd[7:6]}, {32'd1, 2'b01}, "watchdog expiry");
    halt();
    xfer(`TSQ_A_CST, 1'b0, 32'h0);
    chk(rd, 32'h0, "flag cleared");
    xfer(`TSQ_A_CFG, 1'b1, 32'h0000);
    prog[0] = 8'h40;
    prog[1] = 8'h41;
    b = irq_n[1];
    d = ss_n;
    start(16'h8280);
    repeat (30) @(posedge clk);
    xfer(`TSQ_A_CST, 1'b1, 32'h8280);
    repeat (20) @(posedge clk);
    chk({irq_n[1] - b, ss_n - d}, {32'd0, 32'd1}, "single step pause");
    xfer(`TSQ_A_CST, 1'b1, 32'h8680);
    repeat (30) @(posedge clk);
    chk({irq_n[1] - b, ss_n - d}, {32'd1, 32'd2}, "single step resume");
    halt();
    prog[1] = 8'h42;
    b = irq_n[2];
    start(16'h8080);
    repeat (20) @(posedge clk);
    chk(irq_n[2] - b, 0, "software wait");
    xfer(`TSQ_A_CST, 1'b1, 32'h8480);
    wait_irq(2, b);
    chk(irq_n[2] - b, 1, "software release");
    for (int s = 0; s < 2; s++) begin
      halt();
      idle <= 1'b1;
      prog[0] = 8'h40;
      b = irq_n[0];
      start(s ? 16'h8080 : 16'hA080);
      repeat (30) @(posedge clk);
      chk(irq_n[0] - b, s, "idle stop");
      idle <= 1'b0;
      repeat (30) @(posedge clk);
      chk(irq_n[0] - b, 1, "idle resume");
    end
    halt();
    xfer(`TSQ_A_SD, 1'b1, 32'h5);
    prog[0] = 8'h40;
    prog[1] = 8'h41;
    prog[2] = 8'h42;
    prog[3] = 8'h43;
    b = irq_n[3];
    start(16'h8080);
    repeat (40) @(posedge clk);
    chk({irq_t[1] - irq_t[0], irq_n[3] - b}, {32'd7, 32'd1}, "step delay");
    xfer(`TSQ_A_SD, 1'b1, 32'd30);
    // wait high on line 5 and wait low on line 6, every input mode, slower answers as k grows
    for (int k = 0; k < 8; k++) begin
      halt();
      lag <= 4'(k);
      want <= k[2] ? 16'h0000 : 16'h0020;
      xfer(`TSQ_A_SD, 1'b1, 32'd30);
      prog[0] = k[2] ? 8'h26 : 8'h15;
      prog[1] = 8'h42;
      b = irq_n[2];
      start({14'h2020, k[1:0]});
      if (!k[1]) begin
        repeat (60) @(posedge clk);
        chk(irq_n[2] - b, 0, "no edge seen");
        want <= k[2] ? 16'h0040 : 16'h0000;
        repeat (12) @(posedge clk);
        want <= k[2] ? 16'h0000 : 16'h0020;
        t = cyc;
      end
      wait_irq(2, b);
      chk({irq_n[2] - b, irq_t[2] - t < 31}, {32'd1, k[0]}, "input wait");
    end
    stop_test();
  end
endmodule : tb_tsq_top
`default_nettype wire
